// [sxa_pkg.sv]
// Shared constants and types for the six channel converter sequencer.
// Assumes a single 50 MHz clock on both ends of the link.
package sxa_pkg;

    localparam int CLK_NS      = 20;
    localparam int CONV_NS     = 1750;
    localparam int ACQ_NS      = 250;
    localparam int HOLD_MIN_NS = 15;
    // Least times round up to whole cycles
    localparam int CONV_CYC     = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACQ_CYC      = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_MIN_CYC = (HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;

    localparam int NUM_PAIRS = 3;
    localparam int NUM_CHAN  = 6;
    localparam int DATA_W    = 12;
    localparam int ID_W      = 3;
    localparam int WORD_W    = 16;
    localparam int ENTRY_W   = ID_W + DATA_W;
    localparam int VALID_BIT = 15;
    localparam int ID_LSB    = 12;

    localparam logic [ID_W-1:0] MODE_CYCLE_DEF = 3'h6;
    localparam logic [ID_W-1:0] MODE_FIFO_DEF  = 3'h7;
    localparam logic [ID_W-1:0] LAST_CHAN      = 3'h5;

    localparam logic [WORD_W-1:0] WORD_NONE = 16'h0000;

    typedef enum {CV_IDLE, CV_CONV, CV_STORE0, CV_STORE1, CV_ACQ} sxa_conv_st_t;
    typedef enum {RH_IDLE, RH_SETUP, RH_LOW, RH_HIGH} sxa_rd_st_t;

    function automatic logic [WORD_W-1:0] sxa_pack(input logic valid,
                                                   input logic [ENTRY_W-1:0] entry);
        return {valid, entry};
    endfunction

endpackage

// [sxa_if.sv]
// Pin level link between the converter sequencer and its reading host.
// Assumes both ends share the one clock; the data bus is resolved here.
`timescale 1ns/1ns
interface sxa_if;
    logic        pair_a_hold_n;
    logic        pair_b_hold_n;
    logic        pair_c_hold_n;
    logic        mode_sel_0;
    logic        mode_sel_1;
    logic        mode_sel_2;
    logic        rd_n;
    logic        cs_n;
    logic        reset_n;
    logic        busy_n;
    logic [15:0] data;
    logic        data_oe;
    wire  [15:0] bus_data;

    // Released bus shows the inverse so a stale sample stands out
    assign bus_data = data_oe ? data : ~data;

    modport device (
        input  pair_a_hold_n, pair_b_hold_n, pair_c_hold_n,
        input  mode_sel_0, mode_sel_1, mode_sel_2, rd_n, cs_n, reset_n,
        output busy_n, data, data_oe
    );
    modport host (
        output pair_a_hold_n, pair_b_hold_n, pair_c_hold_n,
        output mode_sel_0, mode_sel_1, mode_sel_2, rd_n, cs_n, reset_n,
        input  busy_n, bus_data
    );
endinterface

// [sxa_device.sv]
// Converter end: hold capture, conversion sequencing, result store, read port.
// Assumes link pins are asynchronous to ref_clk_i; analog levels arrive on sample_i.
//
// Operation
// - Host holds pair strobe low fifteen nanoseconds
// - Strobe fall holds both pair inputs together
// - Busy low through whole conversion cycle
// - Read and select low drive result word
// - Conversion 1.75us, acquisition 0.25us per cycle
// - Reads may overlap next conversion start
// - Two converters; strobes pick mux, trigger
// - All three strobes capture six channels
// - Six result registers hold converted values
// - Word: valid bit, channel id, result
// - Mode select: single, cycle or FIFO
// - FIFO mode lets one pair fill six
// - Same cycle strobes convert A, B, C
// - Repeat falls ignored until conversion done
// - Top bit valid, then id, MSB first
// - Reset low clears outputs, stops conversion
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
module sxa_fifo
    import sxa_pkg::*;
#(
    parameter int W     = ENTRY_W,
    parameter int DEPTH = 4
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2) begin : g_chk
        $error("sxa_fifo needs DEPTH of at least 2");
    end

    logic [W-1:0]  mem_ff [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0]   cnt_ff;
    logic [PW-1:0] nxt_wr;
    logic [PW-1:0] nxt_rd;
    logic [PW:0]   nxt_cnt;
    logic          push;
    logic          pop;

    function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    assign in_ready_o  = (cnt_ff != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o  = mem_ff[rd_ff];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        nxt_wr  = push ? inc(wr_ff) : wr_ff;
        nxt_rd  = pop ? inc(rd_ff) : rd_ff;
        nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sxa_device
    import sxa_pkg::*;
#(
    parameter int              CONV_CYCLES     = CONV_CYC,
    parameter int              ACQ_CYCLES      = ACQ_CYC,
    parameter int              FIFO_DEPTH      = 4,
    parameter int              RING_DEPTH      = NUM_CHAN,
    parameter logic [ID_W-1:0] MODE_CYCLE_CODE = MODE_CYCLE_DEF,
    parameter logic [ID_W-1:0] MODE_FIFO_CODE  = MODE_FIFO_DEF
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    input  wire logic [DATA_W-1:0]    sample_i [NUM_CHAN],
    output logic                      converting_o,
    sxa_if.device                     link
);
    localparam int TW = $clog2(((CONV_CYCLES > ACQ_CYCLES) ? CONV_CYCLES : ACQ_CYCLES) + 1);
    localparam int RW = $clog2(RING_DEPTH);
    // Pin vector layout: reset_n, cs_n, rd_n, mode[2:0], hold_n[2:0]
    localparam int PIN_W   = 9;
    localparam int P_RST   = 8;
    localparam int P_CS    = 7;
    localparam int P_RD    = 6;
    localparam int P_MODE  = 3;
    localparam logic [PIN_W-1:0] PIN_IDLE = 9'h1F8;

    if (CONV_CYCLES < 1 || ACQ_CYCLES < 1 || RING_DEPTH < NUM_CHAN
        || MODE_CYCLE_CODE <= LAST_CHAN || MODE_FIFO_CODE <= LAST_CHAN
        || MODE_CYCLE_CODE == MODE_FIFO_CODE) begin : g_chk
        $error("sxa_device parameters out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [PIN_W-1:0] s1_ff, s2_ff, s3_ff;
    logic             clr;
    logic [2:0]       fall;
    logic [2:0]       accept;
    logic             acc_start, acc_end;
    logic [ID_W-1:0]  mode;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s1_ff <= PIN_IDLE;
            s2_ff <= PIN_IDLE;
            s3_ff <= PIN_IDLE;
        end else begin
            s1_ff <= {link.reset_n, link.cs_n, link.rd_n, link.mode_sel_2,
                      link.mode_sel_1, link.mode_sel_0, link.pair_c_hold_n,
                      link.pair_b_hold_n, link.pair_a_hold_n};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign clr       = rst_i | ~s2_ff[P_RST];
    assign fall      = s3_ff[2:0] & ~s2_ff[2:0];
    assign mode      = s2_ff[P_MODE +: ID_W];
    assign acc_start = ~(s2_ff[P_CS] | s2_ff[P_RD]) & (s3_ff[P_CS] | s3_ff[P_RD]);
    assign acc_end   = (s2_ff[P_CS] | s2_ff[P_RD]) & ~(s3_ff[P_CS] | s3_ff[P_RD]);

    ////////////////////////////////////////////////////////////////////////////
    sxa_conv_st_t     st_ff, nxt_st;
    logic [TW-1:0]    tmr_ff, nxt_tmr;
    logic [2:0]       pend_ff, nxt_pend;
    logic [1:0]       q_ff [NUM_PAIRS];
    logic [1:0]       nxt_q [NUM_PAIRS];
    logic [1:0]       qcnt_ff, nxt_qcnt;
    logic [1:0]       cur_ff, nxt_cur;
    logic [DATA_W-1:0] held_ff [NUM_CHAN];
    logic [DATA_W-1:0] nxt_held [NUM_CHAN];
    logic             busy_n_ff, nxt_busy_n;
    logic             conv_ff, nxt_conv;
    logic             f_in_valid, f_in_ready;
    logic [ENTRY_W-1:0] f_in_data;
    logic             f_out_valid, f_out_ready;
    logic [ENTRY_W-1:0] f_out_data;

    assign accept = fall & ~pend_ff;

    always_comb begin
        nxt_st     = st_ff;
        nxt_tmr    = tmr_ff;
        nxt_pend   = pend_ff;
        nxt_q      = q_ff;
        nxt_qcnt   = qcnt_ff;
        nxt_cur    = cur_ff;
        nxt_held   = held_ff;
        nxt_busy_n = busy_n_ff;
        f_in_valid = 1'b0;
        f_in_data  = {ID_W'({cur_ff, 1'b0}), held_ff[{cur_ff, 1'b0}]};
        case (st_ff)
            CV_IDLE: begin
                if (qcnt_ff != 2'h0) begin
                    nxt_cur    = q_ff[0];
                    nxt_q[0]   = q_ff[1];
                    nxt_q[1]   = q_ff[2];
                    nxt_qcnt   = qcnt_ff - 2'h1;
                    nxt_tmr    = TW'(CONV_CYCLES - 1);
                    nxt_busy_n = 1'b0;
                    nxt_st     = CV_CONV;
                end
            end
            CV_CONV: begin
                nxt_tmr = tmr_ff - 1'b1;
                if (tmr_ff == '0) begin
                    nxt_st = CV_STORE0;
                end
            end
            CV_STORE0: begin
                f_in_valid = 1'b1;
                if (f_in_ready) begin
                    nxt_st = CV_STORE1;
                end
            end
            CV_STORE1: begin
                f_in_valid = 1'b1;
                f_in_data  = {ID_W'({cur_ff, 1'b1}), held_ff[{cur_ff, 1'b1}]};
                if (f_in_ready) begin
                    nxt_pend[cur_ff] = 1'b0;
                    nxt_busy_n       = 1'b1;
                    nxt_tmr          = TW'(ACQ_CYCLES - 1);
                    nxt_st           = CV_ACQ;
                end
            end
            CV_ACQ: begin
                nxt_tmr = tmr_ff - 1'b1;
                if (tmr_ff == '0) begin
                    nxt_st = CV_IDLE;
                end
            end
            default: nxt_st = CV_IDLE;
        endcase
        // Accepted strobes queue in A, B, C order behind older ones
        for (int p = 0; p < NUM_PAIRS; p++) begin
            if (accept[p]) begin
                nxt_pend[p]          = 1'b1;
                nxt_q[nxt_qcnt]      = 2'(p);
                nxt_qcnt             = nxt_qcnt + 2'h1;
                nxt_held[2*p]        = sample_i[2*p];
                nxt_held[2*p+1]      = sample_i[2*p+1];
            end
        end
        nxt_conv = ~nxt_busy_n;
    end

    always_ff @(posedge ref_clk_i) begin
        if (clr) begin
            st_ff     <= CV_IDLE;
            tmr_ff    <= '0;
            pend_ff   <= '0;
            q_ff      <= '{default: '0};
            qcnt_ff   <= '0;
            cur_ff    <= '0;
            held_ff   <= '{default: '0};
            busy_n_ff <= 1'b1;
            conv_ff   <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            tmr_ff    <= nxt_tmr;
            pend_ff   <= nxt_pend;
            q_ff      <= nxt_q;
            qcnt_ff   <= nxt_qcnt;
            cur_ff    <= nxt_cur;
            held_ff   <= nxt_held;
            busy_n_ff <= nxt_busy_n;
            conv_ff   <= nxt_conv;
        end
    end

    sxa_fifo #(.W(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (clr),
        .in_valid_i  (f_in_valid),
        .in_ready_o  (f_in_ready),
        .in_data_i   (f_in_data),
        .out_valid_o (f_out_valid),
        .out_ready_i (f_out_ready),
        .out_data_o  (f_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic [DATA_W:0]    res_ff [NUM_CHAN];
    logic [DATA_W:0]    nxt_res [NUM_CHAN];
    logic [ENTRY_W-1:0] ring_ff [RING_DEPTH];
    logic [ENTRY_W-1:0] nxt_ring [RING_DEPTH];
    logic [RW-1:0]      rwr_ff, nxt_rwr, rrd_ff, nxt_rrd;
    logic [RW:0]        rcnt_ff, nxt_rcnt;
    logic [ID_W-1:0]    cyc_ff, nxt_cyc;
    logic [WORD_W-1:0]  word_ff, nxt_word;
    logic               oe_ff, nxt_oe;
    logic               ring_full;
    logic               fifo_mode;
    logic [ID_W-1:0]    ch;

    function automatic logic [RW-1:0] rinc(input logic [RW-1:0] p);
        return (p == RW'(RING_DEPTH - 1)) ? '0 : RW'(p + 1'b1);
    endfunction

    assign ring_full   = (rcnt_ff == (RW+1)'(RING_DEPTH));
    assign fifo_mode   = (mode == MODE_FIFO_CODE);
    // In FIFO mode a full store stalls conversions; otherwise oldest is dropped
    assign f_out_ready = ~(ring_full & fifo_mode);

    always_comb begin
        nxt_res  = res_ff;
        nxt_ring = ring_ff;
        nxt_rwr  = rwr_ff;
        nxt_rrd  = rrd_ff;
        nxt_rcnt = rcnt_ff;
        nxt_cyc  = cyc_ff;
        nxt_word = word_ff;
        nxt_oe   = oe_ff & ~acc_end;
        ch       = (mode == MODE_CYCLE_CODE) ? cyc_ff : mode;
        if (acc_start) begin
            nxt_oe = 1'b1;
            if (fifo_mode) begin
                nxt_word = WORD_NONE;
                if (rcnt_ff != '0) begin
                    nxt_word = sxa_pack(1'b1, ring_ff[rrd_ff]);
                    nxt_rrd  = rinc(rrd_ff);
                    nxt_rcnt = rcnt_ff - 1'b1;
                end
            end else if (ch <= LAST_CHAN) begin
                nxt_word = sxa_pack(res_ff[ch][DATA_W],
                                    {ch, res_ff[ch][DATA_W-1:0]});
                nxt_res[ch][DATA_W] = 1'b0;
                if (mode == MODE_CYCLE_CODE) begin
                    nxt_cyc = (cyc_ff == LAST_CHAN) ? '0 : cyc_ff + 1'b1;
                end
            end else begin
                nxt_word = WORD_NONE;
            end
        end
        // A result landing in the read cycle sets valid after the read clears it
        if (f_out_valid & f_out_ready) begin
            nxt_res[f_out_data[ENTRY_W-1 -: ID_W]] = {1'b1, f_out_data[DATA_W-1:0]};
            nxt_ring[rwr_ff] = f_out_data;
            nxt_rwr          = rinc(rwr_ff);
            if (nxt_rcnt == (RW+1)'(RING_DEPTH)) begin
                nxt_rrd = rinc(nxt_rrd);
            end else begin
                nxt_rcnt = nxt_rcnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (clr) begin
            res_ff  <= '{default: '0};
            ring_ff <= '{default: '0};
            rwr_ff  <= '0;
            rrd_ff  <= '0;
            rcnt_ff <= '0;
            cyc_ff  <= '0;
            word_ff <= WORD_NONE;
            oe_ff   <= 1'b0;
        end else begin
            res_ff  <= nxt_res;
            ring_ff <= nxt_ring;
            rwr_ff  <= nxt_rwr;
            rrd_ff  <= nxt_rrd;
            rcnt_ff <= nxt_rcnt;
            cyc_ff  <= nxt_cyc;
            word_ff <= nxt_word;
            oe_ff   <= nxt_oe;
        end
    end

    assign link.busy_n  = busy_n_ff;
    assign link.data    = word_ff;
    assign link.data_oe = oe_ff;
    assign converting_o = conv_ff;
endmodule

// [sxa_host.sv]
// Reading host end: drives hold strobes, mode select, read strobes and reset.
// Assumes device answers are asynchronous; they pass two flip-flops.
`timescale 1ns/1ns
module sxa_host
    import sxa_pkg::*;
#(
    parameter int HOLD_CYCLES    = 2,
    parameter int RD_LOW_CYCLES  = 8,
    parameter int RD_HIGH_CYCLES = 3
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic [2:0]        hold_req_i,
    input  wire logic              read_req_i,
    input  wire logic [ID_W-1:0]   read_mode_i,
    output logic                   read_ready_o,
    output logic [WORD_W-1:0]      read_word_o,
    output logic                   read_done_o,
    output logic                   busy_o,
    sxa_if.host                    link
);
    if (HOLD_CYCLES < HOLD_MIN_CYC || HOLD_CYCLES + RD_HIGH_CYCLES > 16 || RD_LOW_CYCLES < 6
        || RD_LOW_CYCLES > 15 || RD_HIGH_CYCLES < 3 || RD_HIGH_CYCLES > 15) begin : g_chk
        $error("sxa_host parameters out of range");
    end

    sxa_rd_st_t        st_ff, nxt_st;
    logic [3:0]        cnt_ff, nxt_cnt;
    logic [3:0]        hcnt_ff [NUM_PAIRS];
    logic [3:0]        nxt_hcnt [NUM_PAIRS];
    logic [2:0]        hold_n_ff, nxt_hold_n;
    logic [ID_W-1:0]   mode_ff, nxt_mode;
    logic              rd_n_ff, nxt_rd_n;
    logic              rdy_ff, nxt_rdy;
    logic [WORD_W-1:0] word_ff, nxt_word;
    logic              done_ff, nxt_done;
    logic [WORD_W-1:0] d1_ff, d2_ff;
    logic              b1_ff, busy_ff;
    logic              rst_n_ff;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st     = st_ff;
        nxt_cnt    = cnt_ff;
        nxt_hcnt   = hcnt_ff;
        nxt_hold_n = hold_n_ff;
        nxt_mode   = mode_ff;
        nxt_rd_n   = rd_n_ff;
        nxt_rdy    = rdy_ff;
        nxt_word   = word_ff;
        nxt_done   = 1'b0;
        for (int p = 0; p < NUM_PAIRS; p++) begin
            if (hcnt_ff[p] != 4'h0) begin
                nxt_hcnt[p] = hcnt_ff[p] - 4'h1;
                if (hcnt_ff[p] == 4'(RD_HIGH_CYCLES)) begin
                    nxt_hold_n[p] = 1'b1;
                end
            end else if (hold_req_i[p]) begin
                nxt_hold_n[p] = 1'b0;
                nxt_hcnt[p]   = 4'(HOLD_CYCLES + RD_HIGH_CYCLES - 1);
            end
        end
        case (st_ff)
            RH_IDLE: begin
                if (read_req_i) begin
                    nxt_mode = read_mode_i;
                    nxt_rdy  = 1'b0;
                    nxt_st   = RH_SETUP;
                end
            end
            RH_SETUP: begin
                nxt_rd_n = 1'b0;
                nxt_cnt  = 4'(RD_LOW_CYCLES - 1);
                nxt_st   = RH_LOW;
            end
            RH_LOW: begin
                nxt_cnt = cnt_ff - 4'h1;
                if (cnt_ff == 4'h0) begin
                    nxt_word = d2_ff;
                    nxt_done = 1'b1;
                    nxt_rd_n = 1'b1;
                    nxt_cnt  = 4'(RD_HIGH_CYCLES - 1);
                    nxt_st   = RH_HIGH;
                end
            end
            RH_HIGH: begin
                nxt_cnt = cnt_ff - 4'h1;
                if (cnt_ff == 4'h0) begin
                    nxt_rdy = 1'b1;
                    nxt_st  = RH_IDLE;
                end
            end
            default: nxt_st = RH_IDLE;
        endcase
        // Ready rises with reset_n; the device sees that pin two cycles later
        if (!rst_n_ff) begin
            nxt_rdy = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_ff     <= RH_IDLE;
            cnt_ff    <= 4'h0;
            hcnt_ff   <= '{default: 4'h0};
            hold_n_ff <= 3'h7;
            mode_ff   <= 3'h0;
            rd_n_ff   <= 1'b1;
            rdy_ff    <= 1'b0;
            word_ff   <= WORD_NONE;
            done_ff   <= 1'b0;
            d1_ff     <= WORD_NONE;
            d2_ff     <= WORD_NONE;
            b1_ff     <= 1'b1;
            busy_ff   <= 1'b0;
            rst_n_ff  <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            cnt_ff    <= nxt_cnt;
            hcnt_ff   <= nxt_hcnt;
            hold_n_ff <= nxt_hold_n;
            mode_ff   <= nxt_mode;
            rd_n_ff   <= nxt_rd_n;
            rdy_ff    <= nxt_rdy;
            word_ff   <= nxt_word;
            done_ff   <= nxt_done;
            d1_ff     <= link.bus_data;
            d2_ff     <= d1_ff;
            b1_ff     <= link.busy_n;
            busy_ff   <= ~b1_ff;
            rst_n_ff  <= 1'b1;
        end
    end

    assign link.pair_a_hold_n = hold_n_ff[0];
    assign link.pair_b_hold_n = hold_n_ff[1];
    assign link.pair_c_hold_n = hold_n_ff[2];
    assign link.mode_sel_0    = mode_ff[0];
    assign link.mode_sel_1    = mode_ff[1];
    assign link.mode_sel_2    = mode_ff[2];
    assign link.rd_n          = rd_n_ff;
    assign link.cs_n          = rd_n_ff;
    assign link.reset_n       = rst_n_ff;
    assign read_ready_o       = rdy_ff;
    assign read_word_o        = word_ff;
    assign read_done_o        = done_ff;
    assign busy_o             = busy_ff;
endmodule

// [sxa_checker.sv]
// Pin checker for the converter link; watches interface signals and rst_i only.
// Assumes the device runs with CONV_CYCLES 10 and ACQ_CYCLES 2.
`timescale 1ns/1ns
module sxa_checker (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        pair_a_hold_n,
    input wire logic        rd_n,
    input wire logic        cs_n,
    input wire logic        busy_n,
    input wire logic [15:0] data,
    input wire logic        data_oe
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    a_busy_stands: assert property ($fell(busy_n) |-> !busy_n[*8])
        else $error("busy released early");
    a_acq_gap: assert property ($rose(busy_n) |-> busy_n[*2])
        else $error("acquisition gap short");
    a_read_answer: assert property ($fell(rd_n | cs_n) |-> ##[1:4] data_oe)
        else $error("read not answered");
    a_oe_needs_read: assert property (data_oe |-> !(rd_n && $past(rd_n) &&
        $past(rd_n, 2) && $past(rd_n, 3) && $past(rd_n, 4))) else $error("bus driven idle");
    a_word_id: assert property (data_oe && data[15] |-> data[14:12] <= 3'h5)
        else $error("bad channel id");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> busy_n && !data_oe)
        else $error("outputs live in reset");
    a_word_stands: assert property ($rose(data_oe) |-> ##1 $stable(data)[*3])
        else $error("word changed in read");
    a_hold_starts: assert property ($fell(pair_a_hold_n) |-> ##[1:60] !busy_n)
        else $error("hold did not start");
    c_conv: cover property ($fell(busy_n));
    c_valid: cover property ($rose(data_oe) ##1 data[15]);
    c_empty: cover property ($rose(data_oe) ##1 !data[15]);
endmodule

// [tb_six_channel_adc_sequencer.sv]
// Bench: host and device face each other on one link; bench drives host user side.
// Assumes 50 MHz clock; conversion counts shortened by parameter.
`timescale 1ns/1ns
module tb_six_channel_adc_sequencer;
    import sxa_pkg::*;
    logic              ref_clk_i, rst_i, rreq, rdy, done, busy, conv;
    logic [DATA_W-1:0] smp [NUM_CHAN];
    logic [2:0]        hreq, rmode;
    logic [WORD_W-1:0] word;
    int                err_count, n_tests, seed, ev[6], pq[$];
    bit                vv[6];
    sxa_if lk ();
    sxa_device #(.CONV_CYCLES(10), .ACQ_CYCLES(2)) sxa_device_inst (.ref_clk_i, .rst_i,
        .sample_i(smp), .converting_o(conv), .link(lk.device));
    sxa_host sxa_host_inst (.ref_clk_i, .rst_i, .hold_req_i(hreq), .read_req_i(rreq),
        .read_mode_i(rmode), .read_ready_o(rdy), .read_word_o(word), .read_done_o(done),
        .busy_o(busy), .link(lk.host));
    sxa_checker sxa_checker_inst (.ref_clk_i, .rst_i, .pair_a_hold_n(lk.pair_a_hold_n),
        .rd_n(lk.rd_n), .cs_n(lk.cs_n), .busy_n(lk.busy_n), .data(lk.data),
        .data_oe(lk.data_oe));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Model queues held samples; they become results once the device goes idle
    task automatic hold(input logic [2:0] m, input bit take);
        for (int c = 0; c < 6; c++) begin
            smp[c] = DATA_W'($random(seed));
            if (take && m[c/2]) pq.push_back(c * 4096 + int'(smp[c]));
        end
        hreq = m;
        @(posedge ref_clk_i);
        #1 hreq = 3'h0;
    endtask
    // Invalid words carry no defined result bits, so only the top nibble counts
    task automatic rd(input logic [2:0] md, input int c);
        logic [15:0] e;
        int t;
        e = (c < 0) ? WORD_NONE : {vv[c], 3'(c), vv[c] ? 12'(ev[c]) : 12'h000};
        while (rdy !== 1'b1) @(posedge ref_clk_i) #1;
        rmode = md;
        rreq = 1;
        @(posedge ref_clk_i);
        #1 rreq = 0;
        for (t = 0; done !== 1'b1 && t < 50; t++) @(posedge ref_clk_i) #1;
        if (t == 50) err_count++;
        chk(e[15] ? word : word & 16'hF000, e, "word");
        if (c >= 0 && md != MODE_FIFO_DEF) vv[c] = 0;
    endtask
    task automatic settle();
        int q = 0;
        int v;
        for (int t = 0; t < 600 && q < 20; t++) begin
            @(posedge ref_clk_i) #1;
            q = busy ? 0 : q + 1;
        end
        if (q < 20) err_count++;
        while (pq.size() > 0) begin
            v = pq.pop_front();
            ev[v / 4096] = v % 4096;
            vv[v / 4096] = 1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial begin
        seed = 10;
        hreq = 0;
        rreq = 0;
        rmode = 0;
        rst_i = 1;
        foreach (smp[c]) smp[c] = 0;
        repeat (2) @(posedge ref_clk_i);
        #1 rst_i = 0;
        while (rdy !== 1'b1) @(posedge ref_clk_i) #1;
        repeat (3) @(posedge ref_clk_i);
        #1 hold(3'h7, 1);
        settle();
        for (int c = 0; c < 6; c++) rd(MODE_FIFO_DEF, c);
        rd(MODE_FIFO_DEF, -1);
        $display("fifo order test done");
        hold(3'h2, 1);
        repeat (6) @(posedge ref_clk_i);
        #1 hold(3'h2, 0);
        settle();
        rd(3'h2, 2);
        rd(3'h3, 3);
        rd(3'h2, 2);
        $display("single mode test done");
        hold(3'h5, 1);
        settle();
        for (int c = 0; c < 7; c++) rd(MODE_CYCLE_DEF, c % 6);
        $display("cycle mode test done");
        hold(3'h1, 1);
        rd(3'h0, 0);
        chk({15'h0, conv}, 16'h0001, "converting");
        chk({15'h0, busy}, 16'h0001, "busy");
        settle();
        rd(3'h0, 0);
        $display("overlap test done");
        wrap_up();
    end
endmodule
